//--- common/startup_cfg_pkg.sv
// constants, layouts and types shared by the startup mode and port configuration loader
// Operation
// - switch on forces fixed built-in port framing
// - peripheral port defaults only with PC cable
// - switch off takes parameters from setup words
// - early revisions default one stop, 2400 baud
// - status flag mirrors expansion switch, gated enable
// - later peripheral attach keeps current mode
// - word 0000, nothing attached gives run
// - word 0000, console selects by its switch
// - word 0000, other peripheral gives program
// - word 0100 restores mode before power loss
// - words 0200-0202 give program, monitor, run
// - erasable cassette stores data, read-only holds program
// - auto-transfer switch copies cassette at start-up
package startup_cfg_pkg;

  localparam int CLK_PERIOD_NS  = 10;
  localparam int SETTLE_TIME_NS = 10000;
  localparam int SETTLE_CYCLES  = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0] SETTLE_LAST = 10'(SETTLE_CYCLES - 1);

  // register addresses on the plain port
  localparam logic [15:0] ADDR_MODE_WORD  = 16'h19c8;
  localparam logic [15:0] ADDR_BUILTIN_A  = 16'h19f5;
  localparam logic [15:0] ADDR_BUILTIN_B  = 16'h19f6;
  localparam logic [15:0] ADDR_PERIPH_A   = 16'h19fa;
  localparam logic [15:0] ADDR_PERIPH_B   = 16'h19fb;
  localparam logic [15:0] ADDR_STATUS     = 16'h1a2c;
  localparam logic [15:0] ADDR_RETAINED   = 16'h1a2d;
  localparam logic [15:0] ADDR_CONTROL    = 16'h1a2e;
  localparam logic [15:0] SETUP_RESET     = 16'h0000;

  // power-up mode word values
  localparam logic [15:0] MODEW_CONSOLE   = 16'h0000;
  localparam logic [15:0] MODEW_RETAIN    = 16'h0100;
  localparam logic [7:0]  MODEW_FIXED_HI  = 8'h02;

  // status register bit positions
  localparam int ST_MODE_LO    = 0;
  localparam int ST_FLAG_EXP   = 2;
  localparam int ST_EXP_ACTIVE = 3;
  localparam int ST_INIT_DONE  = 4;
  localparam int ST_COPY_BUSY  = 5;
  localparam int ST_CASS_WR_OK = 6;
  localparam int ST_PBUS_SEL   = 7;
  // control register bit position: expansion enable flag
  localparam int CT_EXP_ENABLE = 0;

  // default framing
  localparam logic [3:0] DEF_DATA_BITS   = 4'h7;
  localparam logic [1:0] DEF_STOP_NEW    = 2'h2;
  localparam logic [1:0] DEF_STOP_OLD    = 2'h1;
  localparam logic [7:0] DEF_BAUD_NEW    = 8'h60;
  localparam logic [7:0] DEF_BAUD_OLD    = 8'h18;

  // cassette geometry: 16K words
  localparam logic [13:0] CASS_LAST_ADDR = 14'h3fff;

  typedef enum logic [1:0] {
    MODE_PROGRAM = 2'b00,
    MODE_MONITOR = 2'b01,
    MODE_RUN     = 2'b10
  } op_mode_e;

  typedef enum logic [1:0] {
    ST_SETTLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_COPY   = 2'b10,
    ST_READY  = 2'b11
  } init_state_e;

  typedef struct packed {
    logic       earlyRev;
    logic [1:0] consoleSel;
    logic       periphOther;
    logic       periphConsole;
    logic       pcCable;
    logic       cassEeprom;
    logic       cassPresent;
    logic       autoXferSw;
    logic       expTermSw;
    logic       commSw;
  } pins_s;

  typedef struct packed {
    logic        stdParams;
    logic [3:0]  dataBits;
    logic        parityEven;
    logic [1:0]  stopBits;
    logic [7:0]  baudHundreds;
    logic [15:0] wordA;
    logic [15:0] wordB;
  } port_cfg_s;

endpackage

//--- logic/cassette_copier.sv
// copies a whole memory cassette into internal program memory
`timescale 1ns/100ps
module cassette_copier
  import startup_cfg_pkg::*;
(
  input  wire logic        sys_clk,     // system clock
  input  wire logic        rst_n,       // async reset
  input  wire logic        start,       // one-cycle start pulse
  output logic             busy,        // copy in progress
  output logic             done,        // one-cycle end pulse
  output logic [13:0]      cassRdAddr,  // cassette read address
  output logic             cassRd,      // cassette read strobe
  input  wire logic [15:0] cassRdData,  // cassette data, cycle after strobe
  output logic [13:0]      progWrAddr,  // program memory address
  output logic [15:0]      progWrData,  // program memory data
  output logic             progWe       // program memory write
);

  logic        issuing_reg;
  logic        pendValid_reg;
  logic        pendLast_reg;
  logic [13:0] pendAddr_reg;
  logic        busy_reg;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      issuing_reg <= 1'b0;
      cassRdAddr  <= 14'h0000;
    end
    else if (start && !busy_reg)
    begin
      issuing_reg <= 1'b1;
      cassRdAddr  <= 14'h0000;
    end
    else if (issuing_reg)
    begin
      if (cassRdAddr == CASS_LAST_ADDR)
        issuing_reg <= 1'b0;
      else
        cassRdAddr <= cassRdAddr + 14'h0001;
    end
  end

  assign cassRd = issuing_reg;

  // data returns one cycle after the strobe; register it before writing
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pendValid_reg <= 1'b0;
      pendLast_reg  <= 1'b0;
      pendAddr_reg  <= 14'h0000;
      progWe        <= 1'b0;
      progWrAddr    <= 14'h0000;
      progWrData    <= 16'h0000;
      done          <= 1'b0;
    end
    else
    begin
      pendValid_reg <= issuing_reg;
      pendLast_reg  <= issuing_reg && (cassRdAddr == CASS_LAST_ADDR);
      pendAddr_reg  <= cassRdAddr;
      progWe        <= pendValid_reg;
      progWrAddr    <= pendAddr_reg;
      progWrData    <= cassRdData;
      done          <= pendValid_reg && pendLast_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      busy_reg <= 1'b0;
    else if (start)
      busy_reg <= 1'b1;
    else if (done)
      busy_reg <= 1'b0;
  end

  assign busy = busy_reg;

  // each program write carries the word read two cycles earlier
  AST_COPY_PIPE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    progWe |-> $past(cassRd, 2) && progWrAddr == $past(cassRdAddr, 2))
    else $error("program write not matched to cassette read");

endmodule

//--- logic/startup_mode_port_config.sv
// power-up mode selection, serial port setup and cassette handling
`timescale 1ns/100ps
module startup_mode_port_config
  import startup_cfg_pkg::*;
(
  input  wire logic        sys_clk,       // system clock, 100 MHz
  input  wire logic        rst_n,         // async reset, power-up
  input  wire logic [15:0] regAddr,       // register address
  input  wire logic [15:0] regWdata,      // register write data
  input  wire logic        regWrite,      // write strobe
  input  wire logic        regRead,       // read strobe
  output logic [15:0]      regRdata,      // read data, next cycle
  input  wire pins_s       pinsAsync,     // switches and attach pins
  output port_cfg_s        builtinCfg,    // built-in port setup
  output port_cfg_s        periphCfg,     // peripheral port setup
  output op_mode_e         opMode,        // operating mode
  output logic             flagExpTerm,   // expansion terminal flag
  output logic             expTermActive, // expansion terminal in effect
  output logic             periphBusSel,  // peripheral bus chosen
  output logic             initDone,      // power-up finished
  output logic             cassWriteOk,   // cassette program writable
  output logic             ioStoreOk,     // cassette may hold i/o data
  output logic [13:0]      cassRdAddr,    // cassette read address
  output logic             cassRd,        // cassette read strobe
  input  wire logic [15:0] cassRdData,    // cassette read data
  output logic [13:0]      progWrAddr,    // program memory address
  output logic [15:0]      progWrData,    // program memory data
  output logic             progWe         // program memory write
);

  function automatic op_mode_e modeFromCode(input logic [7:0] code);
    case (code)
      8'h00:   modeFromCode = MODE_PROGRAM;
      8'h01:   modeFromCode = MODE_MONITOR;
      8'h02:   modeFromCode = MODE_RUN;
      default: modeFromCode = MODE_PROGRAM;
    endcase
  endfunction

  pins_s       pinsS1_reg;
  pins_s       pinsS2_reg;
  pins_s       pinsS3_reg;
  pins_s       pins_reg;
  init_state_e state_reg;
  init_state_e state_next;
  logic [9:0]  settle_reg;
  logic [15:0] modeWord_reg;
  logic [15:0] builtinA_reg;
  logic [15:0] builtinB_reg;
  logic [15:0] periphA_reg;
  logic [15:0] periphB_reg;
  logic [15:0] control_reg;
  op_mode_e    retained_reg;
  op_mode_e    mode_reg;
  op_mode_e    mode_next;
  logic        commSw_reg;
  logic        expSw_reg;
  logic        early_reg;
  logic        cassPresent_reg;
  logic        cassEeprom_reg;
  logic [15:0] latBuiltinA_reg;
  logic [15:0] latBuiltinB_reg;
  logic [15:0] latPeriphA_reg;
  logic [15:0] latPeriphB_reg;
  logic        copyStart;
  logic        copyBusy;
  logic        copyDone;
  port_cfg_s   stdCfg;
  logic [15:0] status;

  // three stages; a change counts once stages two and three agree
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pinsS1_reg <= '0;
      pinsS2_reg <= '0;
      pinsS3_reg <= '0;
      pins_reg   <= '0;
    end
    else
    begin
      pinsS1_reg <= pinsAsync;
      pinsS2_reg <= pinsS1_reg;
      pinsS3_reg <= pinsS2_reg;
      if (pinsS2_reg == pinsS3_reg)
        pins_reg <= pinsS3_reg;
    end
  end

  // settle window lets the pin synchronisers fill before sampling
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      settle_reg <= 10'h000;
    else if (state_reg == ST_SETTLE)
      settle_reg <= settle_reg + 10'h001;
  end

  always_comb
  begin
    state_next = state_reg;
    copyStart  = 1'b0;
    case (state_reg)
      ST_SETTLE:
        if (settle_reg == SETTLE_LAST)
          state_next = ST_SAMPLE;
      ST_SAMPLE:
      begin
        if (pins_reg.autoXferSw && pins_reg.cassPresent)
        begin
          state_next = ST_COPY;
          copyStart  = 1'b1;
        end
        else
          state_next = ST_READY;
      end
      ST_COPY:
        if (copyDone)
          state_next = ST_READY;
      ST_READY:
        state_next = ST_READY;
      default:
        state_next = ST_SETTLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= ST_SETTLE;
    else
      state_reg <= state_next;
  end

  // power-up mode table
  always_comb
  begin
    mode_next = MODE_PROGRAM;
    if (modeWord_reg == MODEW_CONSOLE)
    begin
      if (pins_reg.periphConsole)
        mode_next = modeFromCode({6'h00, pins_reg.consoleSel});
      else if (pins_reg.periphOther)
        mode_next = MODE_PROGRAM;
      else
        mode_next = MODE_RUN;
    end
    else if (modeWord_reg == MODEW_RETAIN)
      mode_next = retained_reg;
    else if (modeWord_reg[15:8] == MODEW_FIXED_HI)
      mode_next = modeFromCode(modeWord_reg[7:0]);
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      mode_reg <= MODE_PROGRAM;
    else if (state_reg == ST_SAMPLE)
      mode_reg <= mode_next;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      commSw_reg      <= 1'b0;
      expSw_reg       <= 1'b0;
      early_reg       <= 1'b0;
      cassPresent_reg <= 1'b0;
      cassEeprom_reg  <= 1'b0;
      latBuiltinA_reg <= SETUP_RESET;
      latBuiltinB_reg <= SETUP_RESET;
      latPeriphA_reg  <= SETUP_RESET;
      latPeriphB_reg  <= SETUP_RESET;
    end
    else if (state_reg == ST_SAMPLE)
    begin
      commSw_reg      <= pins_reg.commSw;
      expSw_reg       <= pins_reg.expTermSw;
      early_reg       <= pins_reg.earlyRev;
      cassPresent_reg <= pins_reg.cassPresent;
      cassEeprom_reg  <= pins_reg.cassEeprom;
      latBuiltinA_reg <= builtinA_reg;
      latBuiltinB_reg <= builtinB_reg;
      latPeriphA_reg  <= periphA_reg;
      latPeriphB_reg  <= periphB_reg;
    end
  end

  always_comb
  begin
    stdCfg              = '0;
    stdCfg.stdParams    = 1'b1;
    stdCfg.dataBits     = DEF_DATA_BITS;
    stdCfg.parityEven   = 1'b1;
    stdCfg.stopBits     = early_reg ? DEF_STOP_OLD : DEF_STOP_NEW;
    stdCfg.baudHundreds = early_reg ? DEF_BAUD_OLD : DEF_BAUD_NEW;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      builtinCfg <= '0;
      periphCfg  <= '0;
    end
    else if (initDone)
    begin
      if (commSw_reg)
        builtinCfg <= stdCfg;
      else
        builtinCfg <= '{1'b0, 4'h0, 1'b0, 2'h0, 8'h00, latBuiltinA_reg, latBuiltinB_reg};
      if (commSw_reg && pins_reg.pcCable)
        periphCfg <= stdCfg;
      else
        periphCfg <= '{1'b0, 4'h0, 1'b0, 2'h0, 8'h00, latPeriphA_reg, latPeriphB_reg};
    end
  end

  assign periphBusSel = (periphCfg.stdParams) ||
                        (latPeriphA_reg[3:0] == 4'h0) ||
                        (latPeriphA_reg[15:12] == 4'h0 && latPeriphA_reg[3:0] == 4'h1);

  assign flagExpTerm   = expSw_reg;
  assign expTermActive = expSw_reg && control_reg[CT_EXP_ENABLE];

  assign cassWriteOk = cassPresent_reg && cassEeprom_reg;
  assign ioStoreOk   = cassPresent_reg && cassEeprom_reg;

  assign initDone = (state_reg == ST_READY);
  assign opMode   = mode_reg;

  cassette_copier cassette_copier_i (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .start      (copyStart),
    .busy       (copyBusy),
    .done       (copyDone),
    .cassRdAddr (cassRdAddr),
    .cassRd     (cassRd),
    .cassRdData (cassRdData),
    .progWrAddr (progWrAddr),
    .progWrData (progWrData),
    .progWe     (progWe)
  );

  // setup words stay writable; only their power-up copy is used
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      modeWord_reg <= SETUP_RESET;
      builtinA_reg <= SETUP_RESET;
      builtinB_reg <= SETUP_RESET;
      periphA_reg  <= SETUP_RESET;
      periphB_reg  <= SETUP_RESET;
      control_reg  <= SETUP_RESET;
    end
    else if (regWrite)
    begin
      case (regAddr)
        ADDR_MODE_WORD: modeWord_reg <= regWdata;
        ADDR_BUILTIN_A: builtinA_reg <= regWdata;
        ADDR_BUILTIN_B: builtinB_reg <= regWdata;
        ADDR_PERIPH_A:  periphA_reg  <= regWdata;
        ADDR_PERIPH_B:  periphB_reg  <= regWdata;
        ADDR_CONTROL:   control_reg  <= {15'h0000, regWdata[CT_EXP_ENABLE]};
        default:        control_reg  <= control_reg;
      endcase
    end
  end

  // stands in for battery-backed storage: tracks the live mode once running
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      retained_reg <= MODE_PROGRAM;
    else if (regWrite && regAddr == ADDR_RETAINED)
      retained_reg <= modeFromCode({6'h00, regWdata[1:0]});
    else if (initDone)
      retained_reg <= mode_reg;
  end

  always_comb
  begin
    status                = 16'h0000;
    status[ST_MODE_LO+:2] = mode_reg;
    status[ST_FLAG_EXP]   = flagExpTerm;
    status[ST_EXP_ACTIVE] = expTermActive;
    status[ST_INIT_DONE]  = initDone;
    status[ST_COPY_BUSY]  = copyBusy;
    status[ST_CASS_WR_OK] = cassWriteOk;
    status[ST_PBUS_SEL]   = periphBusSel;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      regRdata <= 16'h0000;
    else if (regRead)
    begin
      case (regAddr)
        ADDR_MODE_WORD: regRdata <= modeWord_reg;
        ADDR_BUILTIN_A: regRdata <= builtinA_reg;
        ADDR_BUILTIN_B: regRdata <= builtinB_reg;
        ADDR_PERIPH_A:  regRdata <= periphA_reg;
        ADDR_PERIPH_B:  regRdata <= periphB_reg;
        ADDR_STATUS:    regRdata <= status;
        ADDR_RETAINED:  regRdata <= {14'h0000, retained_reg};
        ADDR_CONTROL:   regRdata <= control_reg;
        default:        regRdata <= 16'h0000;
      endcase
    end
    else
      regRdata <= 16'h0000;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  AST_STD_BUILTIN: assert property ($past(initDone) && commSw_reg |->
    builtinCfg.stdParams && builtinCfg.dataBits == DEF_DATA_BITS && builtinCfg.parityEven)
    else $error("built-in port lacks default framing");
  AST_PERIPH_CABLE: assert property ($past(initDone) && commSw_reg
    |-> periphCfg.stdParams == $past(pins_reg.pcCable))
    else $error("peripheral defaults not tied to cable");
  AST_SETUP_WORDS: assert property ($past(initDone) && !commSw_reg |->
    !builtinCfg.stdParams && builtinCfg.wordA == latBuiltinA_reg && periphCfg.wordB == latPeriphB_reg)
    else $error("setup words not applied");
  AST_EARLY_REV: assert property ($past(initDone) && commSw_reg && early_reg |->
    builtinCfg.stopBits == DEF_STOP_OLD && builtinCfg.baudHundreds == DEF_BAUD_OLD)
    else $error("older revision defaults wrong");
  AST_EXP_FLAG: assert property (state_reg == ST_SAMPLE |=> flagExpTerm == $past(pins_reg.expTermSw) &&
    expTermActive == (flagExpTerm && control_reg[CT_EXP_ENABLE]))
    else $error("expansion flag does not follow sampled switch and enable");
  AST_MODE_HOLD: assert property (initDone |=> $stable(opMode))
    else $error("mode changed after power-up");
  AST_RUN_ALONE: assert property (state_reg == ST_SAMPLE && modeWord_reg == MODEW_CONSOLE &&
    !pins_reg.periphConsole && !pins_reg.periphOther |=> opMode == MODE_RUN)
    else $error("no peripheral should give run");
  AST_CONSOLE_SEL: assert property (state_reg == ST_SAMPLE && modeWord_reg == MODEW_CONSOLE &&
    pins_reg.periphConsole |=> opMode == modeFromCode({6'h00, $past(pins_reg.consoleSel)}))
    else $error("console selector not followed");
  AST_OTHER_PROG: assert property (state_reg == ST_SAMPLE && modeWord_reg == MODEW_CONSOLE &&
    !pins_reg.periphConsole && pins_reg.periphOther |=> opMode == MODE_PROGRAM)
    else $error("other peripheral should give program");
  AST_RETAIN: assert property (state_reg == ST_SAMPLE && modeWord_reg == MODEW_RETAIN
    |=> opMode == $past(retained_reg))
    else $error("retained mode not restored");
  AST_FIXED_MON: assert property (state_reg == ST_SAMPLE && modeWord_reg == 16'h0201
    |=> opMode == MODE_MONITOR)
    else $error("fixed monitor code not honoured");
  AST_CASS_TYPE: assert property (state_reg == ST_SAMPLE |=>
    ioStoreOk == ($past(pins_reg.cassPresent) && $past(pins_reg.cassEeprom)) && cassWriteOk == ioStoreOk)
    else $error("read-only cassette allowed to store data");
  AST_NO_COPY: assert property (state_reg == ST_SAMPLE && !pins_reg.autoXferSw
    |=> state_reg == ST_READY ##1 !copyBusy)
    else $error("copy started with switch off");
  AST_HOLD_SAMPLE: assert property (initDone |=> $stable(latPeriphA_reg) && $stable(commSw_reg))
    else $error("power-up selections changed");

endmodule

//--- verification/periph_side_model.sv
// far side of the peripheral port plus the memory cassette contents
`timescale 1ns/100ps
module periph_side_model
(
  input  wire logic        sys_clk,       // system clock
  input  wire logic [1:0]  kind,          // 0 none, 1 console, 2 other, 3 pc cable
  input  wire logic [1:0]  selKey,        // console selector position
  input  wire logic        cassRd,        // cassette read strobe
  input  wire logic [13:0] cassRdAddr,    // cassette read address
  output logic             pcCable,       // pc cable attached
  output logic             periphConsole, // console attached
  output logic             periphOther,   // non-console device attached
  output logic [1:0]       consoleSel,    // selector switch
  output logic [15:0]      cassRdData     // cassette data
);
  assign consoleSel    = (kind == 2'h1) ? selKey : 2'h0;
  assign periphConsole = (kind == 2'h1);
  assign periphOther   = kind[1];
  assign pcCable       = (kind == 2'h3);

  initial cassRdData = 16'h0000;

  // cassette read port
  // idle data toggles every cycle so a stale word never looks valid
  always @(posedge sys_clk)
    cassRdData <= cassRd ? ({2'b01, cassRdAddr} ^ 16'h00ff) : ~cassRdData;
endmodule

//--- verification/tb_startup_mode_port_config.sv
// self-checking bench for the startup mode and port configuration loader
`timescale 1ns/100ps
module tb_startup_mode_port_config
  import startup_cfg_pkg::*;
;
  logic        sys_clk  = 1'b0;
  logic        rst_n    = 1'b0;
  logic [15:0] regAddr  = 16'h0000;
  logic [15:0] regWdata = 16'h0000;
  logic        regWrite = 1'b0;
  logic        regRead  = 1'b0;
  logic [1:0]  kind     = 2'h0;
  logic [1:0]  selKey   = 2'h0;
  logic [5:0]  sw       = 6'h00;
  logic [13:0] nextAddr = 14'h0000;
  int          errors   = 0;
  int          samplesChecked = 0;
  int          copies   = 0;
  logic [15:0] regRdata, cassRdData, progWrData;
  logic [13:0] cassRdAddr, progWrAddr;
  logic [1:0]  consoleSel;
  logic        pcCable, periphConsole, periphOther, cassRd, progWe;
  logic        flagExpTerm, expTermActive, periphBusSel, initDone, cassWriteOk, ioStoreOk;
  pins_s       pinsAsync;
  port_cfg_s   builtinCfg, periphCfg;
  op_mode_e    opMode;

  // sw holds early, erasable, present, auto-transfer, expansion, comms
  assign pinsAsync = '{earlyRev: sw[5], consoleSel: consoleSel, periphOther: periphOther,
                       periphConsole: periphConsole, pcCable: pcCable, cassEeprom: sw[4],
                       cassPresent: sw[3], autoXferSw: sw[2], expTermSw: sw[1], commSw: sw[0]};

  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end

  startup_mode_port_config startup_mode_port_config_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .pinsAsync(pinsAsync),
    .builtinCfg(builtinCfg), .periphCfg(periphCfg), .opMode(opMode), .flagExpTerm(flagExpTerm),
    .expTermActive(expTermActive), .periphBusSel(periphBusSel), .initDone(initDone),
    .cassWriteOk(cassWriteOk), .ioStoreOk(ioStoreOk), .cassRdAddr(cassRdAddr), .cassRd(cassRd),
    .cassRdData(cassRdData), .progWrAddr(progWrAddr), .progWrData(progWrData), .progWe(progWe));

  periph_side_model periph_side_model_i (
    .sys_clk(sys_clk), .kind(kind), .selKey(selKey), .cassRd(cassRd), .cassRdAddr(cassRdAddr),
    .pcCable(pcCable), .periphConsole(periphConsole), .periphOther(periphOther),
    .consoleSel(consoleSel), .cassRdData(cassRdData));

  task automatic wrap_up();
    if (errors == 0 && samplesChecked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    samplesChecked++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1;
    d = regRdata;
  endtask

  function automatic logic [15:0] dflt(input logic old);
    return {1'b1, DEF_DATA_BITS, 1'b1, old ? DEF_STOP_OLD : DEF_STOP_NEW, old ? DEF_BAUD_OLD : DEF_BAUD_NEW};
  endfunction

  // pins are set while reset is low so they are long stable before sampling
  task automatic boot(input logic [1:0] k, input logic [1:0] s, input logic [5:0] w,
                      input logic [15:0] modeW, input logic [15:0] pA);
    int i;
    @(posedge sys_clk);
    rst_n  <= 1'b0;
    kind   <= k;
    selKey <= s;
    sw     <= w;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    copies = 0;
    nextAddr = 14'h0000;
    wr(ADDR_MODE_WORD, modeW);
    wr(ADDR_BUILTIN_A, 16'h1111);
    wr(ADDR_BUILTIN_B, 16'h2222);
    wr(ADDR_PERIPH_A, pA);
    wr(ADDR_PERIPH_B, 16'h4444);
    wr(ADDR_CONTROL, 16'h0001);
    wr(ADDR_RETAINED, 16'h0001);
    for (i = 0; i < 20000 && initDone !== 1'b1; i++)
      @(posedge sys_clk);
    if (initDone !== 1'b1)
    begin
      errors++;
      wrap_up();
    end
    repeat (3) @(posedge sys_clk);
    #1;
  endtask

  // sampled at the edge, so these are the settled values of the cycle before
  always @(posedge sys_clk)
    if (rst_n && progWe === 1'b1)
    begin
      chk(48'(progWrAddr), 48'(nextAddr));
      chk(48'(progWrData), 48'({2'b01, progWrAddr} ^ 16'h00ff));
      nextAddr = nextAddr + 14'h1;
      copies++;
    end

  initial
  begin
    logic [15:0] v;
    boot(2'h3, 2'h0, 6'b011011, 16'h0202, 16'h0000);
    chk(48'(opMode), 48'(MODE_RUN));
    chk(48'(builtinCfg[47:32]), 48'(dflt(1'b0)));
    chk(48'(periphCfg[47:32]), 48'(dflt(1'b0)));
    chk(48'({flagExpTerm, expTermActive, cassWriteOk, ioStoreOk}), 48'hf);
    chk(48'(copies), 48'h0);
    rd(ADDR_STATUS, v);
    chk(48'(v), 48'h00de);
    wr(ADDR_STATUS, 16'hffff);
    rd(16'h1234, v);
    chk(48'(v), 48'h0);
    rd(ADDR_STATUS, v);
    chk(48'(v), 48'h00de);
    // late attach and switch moves must not disturb the latched choices
    @(posedge sys_clk);
    kind <= 2'h1;
    sw   <= 6'b011000;
    repeat (12) @(posedge sys_clk);
    #1;
    chk(48'(opMode), 48'(MODE_RUN));
    chk(48'({periphCfg.stdParams, flagExpTerm, builtinCfg.stdParams}), 48'h3);
    // dropping the enable must leave the flag but end the mode
    wr(ADDR_CONTROL, 16'h0000);
    #1;
    chk(48'({flagExpTerm, expTermActive}), 48'h2);
    for (int m = 0; m < 2; m++)
    begin
      boot(2'h1, 2'h2, 6'b011000, 16'h0200 + 16'(m), 16'h0000);
      chk(48'(opMode), 48'(m));
    end
    boot(2'h1, 2'h1, 6'b011000, 16'h0000, 16'h1231);
    chk(48'(opMode), 48'(MODE_MONITOR));
    chk(builtinCfg, 48'h0000_1111_2222);
    chk(periphCfg, 48'h0000_1231_4444);
    chk(48'({periphBusSel, flagExpTerm, expTermActive}), 48'h0);
    boot(2'h0, 2'h0, 6'b101101, 16'h0000, 16'h0000);
    chk(48'(opMode), 48'(MODE_RUN));
    chk(48'(builtinCfg[47:32]), 48'(dflt(1'b1)));
    chk(48'({cassWriteOk, ioStoreOk}), 48'h0);
    chk(48'(copies), 48'd16384);
    boot(2'h2, 2'h0, 6'b011000, 16'h0100, 16'h0001);
    chk(48'(opMode), 48'(MODE_MONITOR));
    chk(48'(periphBusSel), 48'h1);
    boot(2'h2, 2'h0, 6'b011000, 16'h0000, 16'h1230);
    chk(48'(opMode), 48'(MODE_PROGRAM));
    chk(48'(periphBusSel), 48'h1);
    wrap_up();
  end
endmodule
